/* File: src/bus_yield_defs.vh */
// constants for the bus yield, abort and instruction status block
// How it works
// - abort seen during float is held until float is removed.
// - read half of read-modify-write drives status code 1011.
// - abort outside the windows raises a high-priority non-resumable abort event.
// - address, data, strobe and direction float before grant asserts; byte enable is raised only in float idle, not in hold.
// - master releases request; processor drops grant when it retakes the bus.
// - a bus cycle in progress completes before the grant, unless an abort cuts it short at T2 and sends it to idle.
// - idle bus with nothing pending floats the cycle after request is sampled and grants a cycle later.
// - request two or more clocks before final state grants right after it.
// - later request may let one more cycle run before the grant.
// - an internally decided cycle on an idle bus completes before grant.
// - instruction begin pulse goes low once per instruction start.
// - user/supervisor output follows the user-mode bit of the state word.
// - interlock output is active during locked set/clear bit instructions.
// - instruction status outputs are timed by execution, not bus cycles.
// - reset_abort low one clock means abort; longer means reset.
// - abort in translation or float idle goes to second state then idle.
// - float sampled low in translation inserts float idle until float rises.
`ifndef BUS_YIELD_DEFS_VH
`define BUS_YIELD_DEFS_VH
`define ST_IDLE 3'h0
`define ST_T1 3'h1
`define ST_TRANS 3'h2
`define ST_FLOAT 3'h3
`define ST_T2 3'h4
`define ST_T3 3'h5
`define ST_T4 3'h6
`define ST_HOLD 3'h7
`define STATUS_RMW_READ 4'hb
`define STATUS_IDLE 4'h0
`endif

/* File: src/instr_status.v */
// instruction status outputs driven from the execution section
`timescale 1ns/10ps
`include "bus_yield_defs.vh"
module instr_status (
	// clock and reset
	input wire clk,
	input wire reset,
	// execution section
	input wire instr_start,
	input wire user_mode_bit,
	input wire set_bit_locked_instr,
	input wire clear_bit_locked_instr,
	input wire locked_instr_done,
	// pins
	output reg instr_begin_pulse_n,
	output reg user_supervisor_indicator,
	output reg interlock_indicator_n
);
	// no bus state is read here: timing follows execution only
	always @(posedge clk) begin
		if (reset) begin
			instr_begin_pulse_n <= 1'b1;
			user_supervisor_indicator <= 1'b0;
			interlock_indicator_n <= 1'b1;
		end else begin
			instr_begin_pulse_n <= ~instr_start;
			user_supervisor_indicator <= user_mode_bit;
			if (instr_start && (set_bit_locked_instr || clear_bit_locked_instr)) begin
				interlock_indicator_n <= 1'b0;
			end else if (locked_instr_done) begin
				interlock_indicator_n <= 1'b1;
			end
		end
	end
endmodule

/* File: src/cpu_bus_yield_abort_status.v */
// bus cycle sequencer with hold handshake, abort filter and instruction status
`timescale 1ns/10ps
`include "bus_yield_defs.vh"
module cpu_bus_yield_abort_status (
	// clock and reset
	input wire clk,
	input wire reset,
	// external pins in
	input wire bus_yield_request_n,
	input wire float_command_n,
	input wire reset_abort_n,
	input wire translation_on,
	// internal bus request
	input wire cycle_req,
	input wire cycle_rmw_read,
	input wire [3:0] cycle_status,
	// execution section
	input wire instr_start,
	input wire user_mode_bit,
	input wire set_bit_locked_instr,
	input wire clear_bit_locked_instr,
	input wire locked_instr_done,
	// bus outputs
	output reg [3:0] bus_cycle_status_lines,
	output reg bus_yield_grant_n,
	output reg bus_drive_oe,
	output reg address_strobe_n,
	output reg data_direction_in_oe,
	output reg high_byte_enable_low,
	output wire cycle_ack,
	// abort results
	output reg abort_retry,
	output reg abort_unrecoverable,
	output reg reset_out,
	// instruction status
	output wire instr_begin_pulse_n,
	output wire user_supervisor_indicator,
	output wire interlock_indicator_n
);
	reg hold_s_r, float_s_r, rab_s_r, rab_d_r;
	reg [2:0] st_r, st_nxt;
	reg pend_abort_r, pend_abort_nxt;
	reg [1:0] low_cnt_r;
	reg late_req_r;
	wire abort_pulse;
	wire in_window;
	wire want_hold;

	// pins released to the far side in hold and float idle
	function floated;
		input [2:0] s;
		begin
			floated = s == `ST_HOLD || s == `ST_FLOAT;
		end
	endfunction

	// a bus cycle opens on the edge that enters T1
	function opens_cycle;
		input [2:0] s;
		begin
			opens_cycle = s == `ST_T1;
		end
	endfunction

	// single sampling edge for all asynchronous pins
	always @(posedge clk) begin
		if (reset) begin
			hold_s_r <= 1'b0;
			float_s_r <= 1'b0;
			rab_s_r <= 1'b0;
			rab_d_r <= 1'b0;
		end else begin
			hold_s_r <= ~bus_yield_request_n;
			float_s_r <= ~float_command_n;
			rab_s_r <= ~reset_abort_n;
			// one more stage so a released pin can be told from a held one
			rab_d_r <= rab_s_r;
		end
	end

	// length of the low level decides abort or reset
	always @(posedge clk) begin
		if (reset) begin
			low_cnt_r <= 2'h0;
			reset_out <= 1'b0;
		end else begin
			if (rab_s_r && low_cnt_r != 2'h3) begin
				low_cnt_r <= low_cnt_r + 2'h1;
			end else if (!rab_s_r) begin
				low_cnt_r <= 2'h0;
			end
			// a second low clock already rules out an abort
			reset_out <= rab_s_r && low_cnt_r != 2'h0;
		end
	end
	// one clock low, now released
	assign abort_pulse = rab_d_r && !rab_s_r && low_cnt_r == 2'h1;
	assign in_window = st_r == `ST_TRANS || st_r == `ST_FLOAT;
	assign want_hold = hold_s_r;
	assign cycle_ack = st_r == `ST_T4;

	// pin low by the end of T2 is early; one that shows up later may be deferred
	always @(posedge clk) begin
		if (reset) begin
			late_req_r <= 1'b0;
		end else if (st_r == `ST_T3) begin
			late_req_r <= !want_hold;
		end else if (st_r == `ST_T1) begin
			late_req_r <= 1'b0;
		end
	end

	always @* begin
		st_nxt = st_r;
		pend_abort_nxt = pend_abort_r;
		case (st_r)
			`ST_IDLE: begin
				if (cycle_req) begin
					st_nxt = `ST_T1;
				// nothing pending: grant straight from idle
				end else if (want_hold) begin
					st_nxt = `ST_HOLD;
				end
			end
			`ST_T1: st_nxt = translation_on ? `ST_TRANS : `ST_T2;
			`ST_TRANS: begin
				if (abort_pulse) begin
					st_nxt = `ST_T2;
					pend_abort_nxt = 1'b1;
				end else if (float_s_r) begin
					st_nxt = `ST_FLOAT;
				end else begin
					st_nxt = `ST_T2;
				end
			end
			`ST_FLOAT: begin
				if (abort_pulse) begin
					pend_abort_nxt = 1'b1;
				end
				if (!float_s_r) begin
					st_nxt = `ST_T2;
				end
			end
			`ST_T2: st_nxt = pend_abort_r ? `ST_IDLE : `ST_T3;
			`ST_T3: st_nxt = `ST_T4;
			`ST_T4: begin
				// cycle_req still high in idle starts another cycle, so the requester drops it after cycle_ack
				if (want_hold && !late_req_r) begin
					st_nxt = `ST_HOLD;
				end else begin
					// a late request lets idle start a pending cycle first
					st_nxt = `ST_IDLE;
				end
			end
			// master gives the bus back by releasing its request
			`ST_HOLD: begin
				if (!want_hold) begin
					st_nxt = `ST_IDLE;
				end
			end
			default: st_nxt = `ST_IDLE;
		endcase
		if (st_r == `ST_T2) begin
			pend_abort_nxt = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			st_r <= `ST_IDLE;
			pend_abort_r <= 1'b0;
			abort_retry <= 1'b0;
			abort_unrecoverable <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pend_abort_r <= pend_abort_nxt;
			// float holds off the response until float removed
			abort_retry <= st_r == `ST_T2 && pend_abort_r;
			// outside the windows retry cannot be promised
			abort_unrecoverable <= abort_pulse && !in_window;
		end
	end

	// pins float from the hold entry, grant follows a cycle later
	always @(posedge clk) begin
		if (reset) begin
			bus_yield_grant_n <= 1'b1;
			bus_drive_oe <= 1'b1;
			address_strobe_n <= 1'b1;
			data_direction_in_oe <= 1'b1;
			high_byte_enable_low <= 1'b0;
			bus_cycle_status_lines <= `STATUS_IDLE;
		end else begin
			bus_drive_oe <= !floated(st_nxt);
			data_direction_in_oe <= !floated(st_nxt);
			high_byte_enable_low <= st_nxt == `ST_FLOAT;
			// grant only after the pins have been released for a full cycle
			bus_yield_grant_n <= !(st_r == `ST_HOLD && st_nxt == `ST_HOLD);
			address_strobe_n <= !opens_cycle(st_nxt);
			if (opens_cycle(st_nxt) && cycle_rmw_read) begin
				bus_cycle_status_lines <= `STATUS_RMW_READ;
			end else if (opens_cycle(st_nxt)) begin
				bus_cycle_status_lines <= cycle_status;
			end else if (st_nxt == `ST_IDLE || st_nxt == `ST_HOLD) begin
				bus_cycle_status_lines <= `STATUS_IDLE;
			end
		end
	end

	instr_status u_instr_status (
		.clk(clk),
		.reset(reset),
		.instr_start(instr_start),
		.user_mode_bit(user_mode_bit),
		.set_bit_locked_instr(set_bit_locked_instr),
		.clear_bit_locked_instr(clear_bit_locked_instr),
		.locked_instr_done(locked_instr_done),
		.instr_begin_pulse_n(instr_begin_pulse_n),
		.user_supervisor_indicator(user_supervisor_indicator),
		.interlock_indicator_n(interlock_indicator_n)
	);
endmodule

/* File: verification/cpu_bus_yield_properties.sv */
// port assertions for the bus yield, abort and status block
`timescale 1ns/10ps
`include "bus_yield_defs.vh"
module cpu_bus_yield_props (
	// clock and reset
	input wire clk,
	input wire reset,
	// pins and execution inputs
	input wire bus_yield_request_n,
	input wire reset_abort_n,
	input wire cycle_rmw_read,
	input wire instr_start,
	input wire user_mode_bit,
	input wire set_bit_locked_instr,
	// outputs
	input wire [3:0] bus_cycle_status_lines,
	input wire bus_yield_grant_n,
	input wire bus_drive_oe,
	input wire address_strobe_n,
	input wire cycle_ack,
	input wire reset_out,
	input wire instr_begin_pulse_n,
	input wire user_supervisor_indicator,
	input wire interlock_indicator_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_granted; !bus_yield_grant_n; endsequence
	sequence s_rst_held; !reset_abort_n [*3]; endsequence
	property p_float; s_granted |-> !bus_drive_oe && address_strobe_n; endproperty
	a_float: assert property (p_float) else $error("grant while bus driven");
	property p_back; $rose(bus_yield_grant_n) |-> $past(bus_yield_request_n); endproperty
	a_back: assert property (p_back) else $error("grant dropped early");
	property p_ack; cycle_ack |-> bus_yield_grant_n; endproperty
	a_ack: assert property (p_ack) else $error("grant inside a cycle");
	property p_rmw; cycle_ack && cycle_rmw_read |-> bus_cycle_status_lines == `STATUS_RMW_READ;
	endproperty
	a_rmw: assert property (p_rmw) else $error("wrong rmw status");
	property p_rst; s_rst_held |-> ##[0:3] reset_out; endproperty
	a_rst: assert property (p_rst) else $error("long pulse gave no reset");
	property p_begin; instr_begin_pulse_n == !$past(instr_start); endproperty
	a_begin: assert property (p_begin) else $error("begin pulse wrong");
	property p_us; user_supervisor_indicator == $past(user_mode_bit); endproperty
	a_us: assert property (p_us) else $error("mode output wrong");
	property p_lock; instr_start && set_bit_locked_instr |=> !interlock_indicator_n; endproperty
	a_lock: assert property (p_lock) else $error("interlock not shown");
endmodule
bind cpu_bus_yield_abort_status cpu_bus_yield_props u_props (.*);

/* File: verification/far_agent.sv */
// far side model: hold master and translation unit on the pins
`timescale 1ns/10ps
module far_agent (
	// bench commands
	input wire hold_go,
	input wire float_go,
	input wire abt_go,
	// pins, pulled high when released
	output wire bus_yield_request_n,
	output wire float_command_n,
	output wire reset_abort_n
);
	assign bus_yield_request_n = !hold_go;
	assign float_command_n = !float_go;
	// abort only when commanded by the bench
	assign reset_abort_n = !abt_go;
endmodule

/* File: verification/cpu_bus_yield_abort_status_tb.sv */
// bench for the bus yield, abort and status block
`timescale 1ns/10ps
module cpu_bus_yield_abort_status_tb;
	reg clk, reset, hold_go, float_go, abt_go, tr_on, creq, crmw, istart, umode, sbit, cbit, idone;
	reg [3:0] cst;
	wire rq_n, float_n, ra_n, gnt_n, oe, ack, aret, aunr, rst_o, begin_n, us, lock_n;
	wire [3:0] st;
	int err_total, checks, n_ret, n_unr, i;
	far_agent u_far_agent (.hold_go(hold_go), .float_go(float_go), .abt_go(abt_go),
		.bus_yield_request_n(rq_n), .float_command_n(float_n), .reset_abort_n(ra_n));
	cpu_bus_yield_abort_status u_cpu_bus_yield_abort_status (.clk(clk), .reset(reset),
		.bus_yield_request_n(rq_n), .float_command_n(float_n), .reset_abort_n(ra_n),
		.translation_on(tr_on), .cycle_req(creq), .cycle_rmw_read(crmw), .cycle_status(cst),
		.instr_start(istart), .user_mode_bit(umode), .set_bit_locked_instr(sbit),
		.clear_bit_locked_instr(cbit), .locked_instr_done(idone), .bus_cycle_status_lines(st),
		.bus_yield_grant_n(gnt_n), .bus_drive_oe(oe), .address_strobe_n(),
		.data_direction_in_oe(), .high_byte_enable_low(), .cycle_ack(ack), .abort_retry(aret),
		.abort_unrecoverable(aunr), .reset_out(rst_o), .instr_begin_pulse_n(begin_n),
		.user_supervisor_indicator(us), .interlock_indicator_n(lock_n));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		n_ret += aret;
		n_unr += aunr;
	end
	task cyc(input int n); repeat (n) @(negedge clk); endtask
	task chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task wgnt(input logic v); for (i = 0; i < 12 && gnt_n !== v; i++) cyc(1); endtask
	task t_idle;
		hold_go = 1;
		cyc(3);
		chk("grant", gnt_n, 0);
		chk("oe", oe, 0);
		hold_go = 0;
		cyc(3);
		chk("release", gnt_n, 1);
		$display("idle hold done");
	endtask
	task t_busy;
		creq = 1;
		crmw = 1;
		cst = 4'h8;
		hold_go = 1;
		for (i = 0; i < 12 && ack !== 1; i++) cyc(1);
		chk("no grant in cycle", gnt_n, 1);
		chk("rmw status", st, 4'hb);
		// request stays up through the acknowledging edge
		cyc(1);
		creq = 0;
		crmw = 0;
		wgnt(0);
		chk("grant after end", i <= 3, 1);
		hold_go = 0;
		wgnt(1);
		$display("busy hold done");
	endtask
	task t_late;
		creq = 1;
		cyc(3);
		// hold first seen in T4: a pending cycle may run before the grant
		hold_go = 1;
		for (i = 0; i < 12 && ack !== 1; i++) cyc(1);
		cyc(1);
		chk("late keeps bus", oe, 1);
		for (i = 0; i < 12 && ack !== 1; i++) cyc(1);
		chk("next cycle runs", ack, 1);
		chk("no grant in cycle", gnt_n, 1);
		cyc(1);
		creq = 0;
		wgnt(0);
		chk("late grant", i, 1);
		hold_go = 0;
		wgnt(1);
		$display("late hold done");
	endtask
	task t_abort;
		tr_on = 1;
		float_go = 1;
		creq = 1;
		for (i = 0; i < 12 && oe !== 0; i++) cyc(1);
		abt_go = 1;
		cyc(1);
		abt_go = 0;
		cyc(4);
		chk("held off", n_ret[3:0], 0);
		float_go = 0;
		creq = 0;
		cyc(6);
		chk("retry", n_ret[3:0], 1);
		tr_on = 0;
		abt_go = 1;
		cyc(1);
		abt_go = 0;
		cyc(6);
		chk("late abort", n_unr[3:0], 1);
		$display("abort done");
	endtask
	task t_instr;
		for (int k = 0; k < 2; k++) begin
			umode = !k[0];
			sbit = !k[0];
			cbit = k[0];
			istart = 1;
			cyc(1);
			istart = 0;
			chk("begin pulse", begin_n, 0);
			chk("mode", us, !k[0]);
			chk("lock", lock_n, 0);
			idone = 1;
			cyc(1);
			idone = 0;
			cyc(1);
			chk("unlock", lock_n, 1);
		end
		$display("status done");
	endtask
	task t_reset;
		abt_go = 1;
		cyc(5);
		chk("reset out", rst_o, 1);
		abt_go = 0;
		$display("reset pulse done");
	endtask
	initial begin
		{reset, hold_go, float_go, abt_go, tr_on, creq, crmw} = 7'h40;
		{istart, umode, sbit, cbit, idone} = 5'h00;
		cst = 4'h0;
		repeat (6) @(negedge clk);
		reset = 0;
		cyc(1);
		t_idle;
		t_busy;
		t_late;
		t_abort;
		t_instr;
		t_reset;
		close_out;
	end
	// well beyond the fewer than one hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		close_out;
	end
endmodule
